// ### rtl/mic_consts.svh
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH
// Notes on behaviour
// - Nonmaskable request on selected edge, ignores mask.
// - Nonmaskable wins; accepted at instruction end.
// - Accepting nonmaskable sets the mask bit.
// - Nonmaskable uses vector 3 at 0x0006.
// - Each external line: low level or falling edge.
// - Mask blocks all lines; per-line enables.
// - Accepting maskable request sets mask bit.
// - Level-sensed lines read live, no latch.
// - Edge captured only when enabled, even masked.
// - Line zero highest, line seven lowest.
// - Lines sensed regardless of pin direction.
// - Nineteen internal sources, masked and enabled.
// - Internal flags are never cleared here.
// - Peripheral flag clears after read-then-write zero.
// - Vanished request: next pending, else reset vector; a vanished external line keeps its own vector while another external line pends.
// - No evaluation after condition-code-writing instructions.
// - Edge requests stay latched across deferral.
// - Decision takes 2 states external, 1 internal.
// - Internal request wakes the sleeping processor.
// - Word accesses force address bit zero low.
// - Condition codes stacked in both bytes.
// - Edge select: 0 falling, 1 rising.
// - Sense select: 0 level, 1 falling edge.
// - Latched edge survives clearing its enable.
// - Reset disables all external lines.

`define MIC_SYSCTRL_ADDR 16'hffc4
`define MIC_SENSE_ADDR 16'hffc6
`define MIC_ENABLE_ADDR 16'hffc7
`define MIC_PENDING_ADDR 16'hffc8
`define MIC_SYSCTRL_RESET 8'h09
`define MIC_SYSCTRL_FIXED 8'h08
`define MIC_EDGE_SEL_BIT 2
`define MIC_SENSE_RESET 8'h00
`define MIC_ENABLE_RESET 8'h00
`define MIC_NMI_VECTOR 8'h03
`define MIC_EXT_VECTOR_BASE 8'h04
`define MIC_INT_VECTOR_BASE 8'h0c
`define MIC_RESET_VECTOR 8'h00
`define MIC_DECIDE_EXT 2'h2
`define MIC_DECIDE_INT 2'h1
`define MIC_PC_SLOT 16'h0002
`define MIC_CC_SLOT 16'h0004
`endif

// ### rtl/mic_interrupt_controller.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "mic_consts.svh"

module mic_interrupt_controller #(
    parameter int NUM_INT = 19
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic nonmaskablePin,
    input wire logic [7:0] maskableExternalLines,
    input wire logic [NUM_INT-1:0] internalFlags,
    input wire logic [NUM_INT-1:0] internalEnables,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic instrEnd,
    input wire logic instrWritesCc,
    input wire logic ccMask,
    input wire logic [7:0] ccValue,
    input wire logic [15:0] pcValue,
    input wire logic [15:0] spValue,
    input wire logic sleeping,
    input wire logic rteStrobe,
    input wire logic [15:0] rteCcWord,
    input wire logic [15:0] memRdata,
    output logic [15:0] memAddr,
    output logic [15:0] memWdata,
    output logic memWrite,
    output logic memRead,
    output logic setMask,
    output logic pcLoad,
    output logic [15:0] newPc,
    output logic [15:0] newSp,
    output logic wakeCore,
    output logic [7:0] ccRestore,
    output logic excBusy
);

    if (NUM_INT < 1 || NUM_INT > 32) begin : g_bad_num_int
        $error("NUM_INT must lie between 1 and 32.");
    end

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------

    logic [1:0] rstSync_q;
    logic rstN;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    assign rstN = rstSync_q[1];

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Returns the lowest set bit index plus a found flag in bit 5.
    function automatic logic [5:0] pickLowest(input logic [31:0] req);
        logic [5:0] res;
        res = 6'h00;
        for (int i = 31; i >= 0; i--) begin
            if (req[i]) begin
                res = {1'b1, 5'(i)};
            end
        end
        return res;
    endfunction : pickLowest

    // Word accesses ignore the least significant address bit.
    function automatic logic [15:0] wordAddr(input logic [15:0] a);
        return {a[15:1], 1'b0};
    endfunction : wordAddr

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------

    mic_pkg::mic_regs_t r_q;
    mic_pkg::mic_regs_t r_d;

    logic [7:0] extPend;
    logic [31:0] intPend;
    logic [5:0] extPick;
    logic [5:0] intPick;
    mic_pkg::mic_src_t bestKind;
    logic [4:0] bestIdx;
    logic [8:0] lvlNext;
    logic nmiEdge;
    logic [7:0] fallEdge;
    logic [7:0] vecNum;

    always_comb begin
        r_d = r_q;
        r_d.memWe = 1'b0;
        r_d.memRe = 1'b0;
        r_d.setMask = 1'b0;
        r_d.pcLoad = 1'b0;
        r_d.wake = 1'b0;

        // Three-stage synchronisers; a level counts once stages two and three agree.
        r_d.syncA = {nonmaskablePin, maskableExternalLines};
        r_d.syncB = r_q.syncA;
        r_d.syncC = r_q.syncB;
        for (int i = 0; i < 9; i++) begin
            lvlNext[i] = (r_q.syncB[i] == r_q.syncC[i]) ? r_q.syncC[i] : r_q.pinLvl[i];
        end
        r_d.pinLvl = lvlNext;

        // Nonmaskable edge, falling or rising by the select bit.
        if (r_q.sysCtrl[`MIC_EDGE_SEL_BIT]) begin
            nmiEdge = ~r_q.pinLvl[8] & lvlNext[8];
        end else begin
            nmiEdge = r_q.pinLvl[8] & ~lvlNext[8];
        end
        fallEdge = r_q.pinLvl[7:0] & ~lvlNext[7:0];

        // Pending requests.
        for (int i = 0; i < 8; i++) begin
            if (r_q.senseSel[i]) begin
                extPend[i] = r_q.edgeLatch[i] & ~ccMask;
            end else begin
                extPend[i] = r_q.lineEn[i] & ~r_q.pinLvl[i] & ~ccMask;
            end
        end
        intPend = 32'h0;
        intPend[NUM_INT-1:0] = internalFlags & internalEnables & {NUM_INT{~ccMask}};
        extPick = pickLowest({24'h0, extPend});
        intPick = pickLowest(intPend);
        if (r_q.nmiLatch) begin
            bestKind = mic_pkg::SRC_NMI;
            bestIdx = 5'h0;
        end else if (extPick[5]) begin
            bestKind = mic_pkg::SRC_EXT;
            bestIdx = extPick[4:0];
        end else if (intPick[5]) begin
            bestKind = mic_pkg::SRC_INT;
            bestIdx = intPick[4:0];
        end else begin
            bestKind = mic_pkg::SRC_NONE;
            bestIdx = 5'h0;
        end

        case (r_q.srcKind)
            mic_pkg::SRC_NMI: vecNum = `MIC_NMI_VECTOR;
            mic_pkg::SRC_EXT: vecNum = `MIC_EXT_VECTOR_BASE + {3'h0, r_q.srcIdx};
            mic_pkg::SRC_INT: vecNum = `MIC_INT_VECTOR_BASE + {3'h0, r_q.srcIdx};
            default: vecNum = `MIC_RESET_VECTOR;
        endcase

        // Sleeping core wakes on a pending, unmasked, enabled internal request.
        if (sleeping && intPick[5]) begin
            r_d.wake = 1'b1;
        end

        // Register port.
        if (regWrite) begin
            case (regAddr)
                `MIC_SYSCTRL_ADDR: r_d.sysCtrl = regWdata | `MIC_SYSCTRL_FIXED;
                `MIC_SENSE_ADDR: r_d.senseSel = regWdata;
                `MIC_ENABLE_ADDR: r_d.lineEn = regWdata;
                default: ;
            endcase
        end
        if (regRead) begin
            case (regAddr)
                `MIC_SYSCTRL_ADDR: r_d.rdData = r_q.sysCtrl;
                `MIC_SENSE_ADDR: r_d.rdData = r_q.senseSel;
                `MIC_ENABLE_ADDR: r_d.rdData = r_q.lineEn;
                `MIC_PENDING_ADDR: r_d.rdData = r_q.edgeLatch;
                default: r_d.rdData = 8'h00;
            endcase
        end

        if (rteStrobe) begin
            r_d.ccRestore = rteCcWord[15:8];
        end

        // Sequencer; internal flags are read only, never cleared here
        case (r_q.state)
            mic_pkg::ST_IDLE: begin
                // Evaluation is skipped after a condition-code write.
                if (instrEnd && !instrWritesCc && bestKind != mic_pkg::SRC_NONE) begin
                    r_d.state = mic_pkg::ST_DECIDE;
                    r_d.excBusy = 1'b1;
                    r_d.srcKind = bestKind;
                    r_d.srcIdx = bestIdx;
                    r_d.decCnt = (bestKind == mic_pkg::SRC_INT) ?
                        `MIC_DECIDE_INT - 2'h1 : `MIC_DECIDE_EXT - 2'h1;
                end
            end
            mic_pkg::ST_DECIDE: begin
                if (r_q.decCnt != 2'h0) begin
                    r_d.decCnt = r_q.decCnt - 2'h1;
                end else begin
                    // A request gone meanwhile yields to the next one or to reset; a gone external line keeps its index while another external line pends.
                    if (!(r_q.srcKind == mic_pkg::SRC_NMI) && bestKind != r_q.srcKind) begin
                        r_d.srcKind = bestKind;
                        r_d.srcIdx = bestIdx;
                    end else if (r_q.srcKind == mic_pkg::SRC_INT &&
                                 !intPend[r_q.srcIdx]) begin
                        r_d.srcKind = bestKind;
                        r_d.srcIdx = bestIdx;
                    end
                    r_d.setMask = 1'b1;
                    r_d.state = mic_pkg::ST_PUSH_PC;
                    r_d.memWe = 1'b1;
                    r_d.memAddr = wordAddr(spValue - `MIC_PC_SLOT);
                    r_d.memWdata = pcValue;
                end
            end
            mic_pkg::ST_PUSH_PC: begin
                r_d.state = mic_pkg::ST_PUSH_CC;
                r_d.memWe = 1'b1;
                r_d.memAddr = wordAddr(spValue - `MIC_CC_SLOT);
                r_d.memWdata = {ccValue, ccValue};
            end
            mic_pkg::ST_PUSH_CC: begin
                r_d.state = mic_pkg::ST_FETCH;
                r_d.memRe = 1'b1;
                r_d.memAddr = wordAddr({7'h0, vecNum, 1'b0});
                r_d.newSp = wordAddr(spValue - `MIC_CC_SLOT);
            end
            mic_pkg::ST_FETCH: begin
                r_d.state = mic_pkg::ST_WAIT;
            end
            mic_pkg::ST_WAIT: begin
                r_d.newPc = memRdata;
                r_d.pcLoad = 1'b1;
                r_d.state = mic_pkg::ST_LOAD;
            end
            mic_pkg::ST_LOAD: begin
                r_d.excBusy = 1'b0;
                r_d.srcKind = mic_pkg::SRC_NONE;
                r_d.state = mic_pkg::ST_IDLE;
            end
            default: begin
                r_d.state = mic_pkg::ST_IDLE;
                r_d.excBusy = 1'b0;
            end
        endcase

        // Latch update: the acceptance clear loses to a fresh edge.
        if (r_d.setMask && r_d.srcKind == mic_pkg::SRC_NMI) begin
            r_d.nmiLatch = 1'b0;
        end
        if (nmiEdge) begin
            r_d.nmiLatch = 1'b1;
        end
        for (int i = 0; i < 8; i++) begin
            if (r_d.setMask && r_d.srcKind == mic_pkg::SRC_EXT &&
                r_d.srcIdx == 5'(i) && r_q.senseSel[i]) begin
                r_d.edgeLatch[i] = 1'b0;
            end
            if (fallEdge[i] && r_q.lineEn[i] && r_q.senseSel[i]) begin
                r_d.edgeLatch[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            r_q <= '0;
            r_q.syncA <= 9'h1ff;
            r_q.syncB <= 9'h1ff;
            r_q.syncC <= 9'h1ff;
            r_q.pinLvl <= 9'h1ff;
            r_q.sysCtrl <= `MIC_SYSCTRL_RESET;
            r_q.senseSel <= `MIC_SENSE_RESET;
            r_q.lineEn <= `MIC_ENABLE_RESET;
            r_q.state <= mic_pkg::ST_IDLE;
            r_q.srcKind <= mic_pkg::SRC_NONE;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    assign regRdata = r_q.rdData;
    assign memAddr = r_q.memAddr;
    assign memWdata = r_q.memWdata;
    assign memWrite = r_q.memWe;
    assign memRead = r_q.memRe;
    assign setMask = r_q.setMask;
    assign pcLoad = r_q.pcLoad;
    assign newPc = r_q.newPc;
    assign newSp = r_q.newSp;
    assign wakeCore = r_q.wake;
    assign ccRestore = r_q.ccRestore;
    assign excBusy = r_q.excBusy;

endmodule : mic_interrupt_controller

// ### rtl/mic_pkg.sv
package mic_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_DECIDE = 7'b0000010,
        ST_PUSH_PC = 7'b0000100,
        ST_PUSH_CC = 7'b0001000,
        ST_FETCH = 7'b0010000,
        ST_WAIT = 7'b0100000,
        ST_LOAD = 7'b1000000
    } mic_state_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_NMI = 2'h1,
        SRC_EXT = 2'h2,
        SRC_INT = 2'h3
    } mic_src_t;

    typedef struct packed {
        logic [8:0] syncA;
        logic [8:0] syncB;
        logic [8:0] syncC;
        logic [8:0] pinLvl;
        logic [7:0] sysCtrl;
        logic [7:0] senseSel;
        logic [7:0] lineEn;
        logic nmiLatch;
        logic [7:0] edgeLatch;
        mic_state_t state;
        logic [1:0] decCnt;
        mic_src_t srcKind;
        logic [4:0] srcIdx;
        logic [7:0] rdData;
        logic [15:0] memAddr;
        logic [15:0] memWdata;
        logic memWe;
        logic memRe;
        logic setMask;
        logic pcLoad;
        logic [15:0] newPc;
        logic [15:0] newSp;
        logic wake;
        logic [7:0] ccRestore;
        logic excBusy;
    } mic_regs_t;

endpackage : mic_pkg

// ### verification/mic_mem_model.sv
`timescale 1ns/1ps
module mic_mem_model (
    input wire logic sys_clk,
    input wire logic memRead,
    input wire logic [15:0] memAddr,
    output logic [15:0] memRdata
);
    logic [1:0] holdCnt = 2'h0;
    initial memRdata = 16'h0000;
    // Read data hold two cycles, then the bus inverts each cycle so stale data match only every other cycle.
    always @(posedge sys_clk) begin
        if (memRead) begin
            memRdata <= {8'h40, memAddr[7:0]};
            holdCnt <= 2'h2;
        end else if (holdCnt != 2'h0) begin
            holdCnt <= holdCnt - 2'h1;
        end else begin
            memRdata <= ~memRdata;
        end
    end
endmodule : mic_mem_model

// ### verification/mic_props.sv
`timescale 1ns/1ps
module mic_props (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic instrEnd,
    input wire logic instrWritesCc,
    input wire logic excBusy,
    input wire logic setMask,
    input wire logic memWrite,
    input wire logic memRead,
    input wire logic [15:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic [15:0] spValue,
    input wire logic [15:0] pcValue,
    input wire logic [7:0] ccValue,
    input wire logic pcLoad,
    input wire logic [15:0] newSp,
    input wire logic rteStrobe,
    input wire logic [15:0] rteCcWord,
    input wire logic [7:0] ccRestore
);
    logic [7:0] rteHi;
    assign rteHi = rteCcWord[15:8];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_PC_PUSH: assert property (setMask |-> memWrite && memWdata == pcValue
        && memAddr == ((spValue - 16'h2) & 16'hfffe)) else $error("PC push wrong");
    AST_CC_PUSH: assert property (setMask |=> memWrite && memWdata == {ccValue, ccValue}
        && memAddr == ((spValue - 16'h4) & 16'hfffe)) else $error("CC push wrong");
    AST_DECIDE: assert property ($rose(excBusy) |-> ##[1:2] setMask)
        else $error("Decision time wrong");
    AST_DEFER: assert property (instrEnd && instrWritesCc && !excBusy |=> !excBusy)
        else $error("Request taken after CC write");
    AST_VEC_READ: assert property (memRead |-> memAddr < 16'h0040 && !memAddr[0])
        else $error("Vector address wrong");
    AST_LOAD: assert property (pcLoad |-> $past(memRead, 2) && newSp == spValue - 16'h4)
        else $error("Load out of step");
    AST_RESTORE: assert property (rteStrobe |=> ccRestore == $past(rteHi))
        else $error("CC restore wrong");
    AST_BUSY_LEN: assert property ($rose(excBusy) |-> excBusy[*6] ##[1:2] !excBusy)
        else $error("Sequence length wrong");
endmodule : mic_props

bind mic_interrupt_controller mic_props i_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .instrEnd(instrEnd), .instrWritesCc(instrWritesCc), .excBusy(excBusy), .setMask(setMask),
    .memWrite(memWrite), .memRead(memRead), .memAddr(memAddr), .memWdata(memWdata),
    .spValue(spValue), .pcValue(pcValue), .ccValue(ccValue), .pcLoad(pcLoad), .newSp(newSp),
    .rteStrobe(rteStrobe), .rteCcWord(rteCcWord), .ccRestore(ccRestore));

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic nmiPin = 1'b1;
    logic [7:0] extLines = 8'hff;
    logic [18:0] intFlags = '0, intEn = '0;
    logic [15:0] regAddr = 16'h0, pcValue = 16'h0, spValue = 16'h0, rteWord = 16'h0;
    logic [7:0] regWdata = 8'h0, ccValue = 8'h0;
    logic regWrite = 0, regRead = 0, instrEnd = 0, ccWr = 0, ccMask = 1, sleeping = 0, rte = 0;
    logic [15:0] memRdata, memAddr, memWdata, newPc, newSp;
    logic [7:0] regRdata, ccRestore;
    logic memWrite, memRead, setMask, pcLoad, wakeCore, excBusy, rdPend = 1'b0;
    logic [33:0] expQ[$];
    int n_mismatch = 0, n_checks = 0, seed = 89613, j;

    mic_interrupt_controller i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .nonmaskablePin(nmiPin), .maskableExternalLines(extLines), .internalFlags(intFlags),
        .internalEnables(intEn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .instrEnd(instrEnd), .instrWritesCc(ccWr),
        .ccMask(ccMask), .ccValue(ccValue), .pcValue(pcValue), .spValue(spValue),
        .sleeping(sleeping), .rteStrobe(rte), .rteCcWord(rteWord), .memRdata(memRdata),
        .memAddr(memAddr), .memWdata(memWdata), .memWrite(memWrite), .memRead(memRead),
        .setMask(setMask), .pcLoad(pcLoad), .newPc(newPc), .newSp(newSp), .wakeCore(wakeCore),
        .ccRestore(ccRestore), .excBusy(excBusy));
    mic_mem_model i_mem (.sys_clk(sys_clk), .memRead(memRead), .memAddr(memAddr),
        .memRdata(memRdata));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cmp(input logic [33:0] seen);
        chk("bus event", seen, (expQ.size() > 0) ? expQ.pop_front() : '1);
    endtask : cmp

    // ----------------------------------------
    // Output watcher
    // ----------------------------------------
    always @(posedge sys_clk) begin
        rdPend <= regRead;
        if (memWrite) cmp({2'd0, memAddr, memWdata});
        if (memRead) cmp({2'd1, memAddr, 16'h0});
        if (pcLoad) cmp({2'd2, newSp, newPc});
        if (rdPend) cmp({2'd3, 24'h0, regRdata});
    end

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        expQ.push_back({2'd3, 24'h0, e});
        @(posedge sys_clk);
        regRead <= 1'b0;
    endtask : rd

    task automatic pulse(input logic cw);
        @(posedge sys_clk);
        instrEnd <= 1'b1;
        ccWr <= cw;
        @(posedge sys_clk);
        instrEnd <= 1'b0;
        ccWr <= 1'b0;
    endtask : pulse

    // An instruction end that must not start a sequence; any bus event is unexpected.
    task automatic quiet(input logic cw);
        pulse(cw);
        idle(12);
    endtask : quiet

    task automatic take(input logic [7:0] vec);
        logic [15:0] sp, pc;
        logic [7:0] cc;
        int k;
        sp = {4'h1, 11'($random(seed)), 1'b0};
        pc = 16'($random(seed));
        cc = 8'($random(seed));
        spValue <= sp;
        pcValue <= pc;
        ccValue <= cc;
        expQ.push_back({2'd0, sp - 16'h2, pc});
        expQ.push_back({2'd0, sp - 16'h4, cc, cc});
        expQ.push_back({2'd1, 8'h0, vec[6:0], 1'b0, 16'h0});
        expQ.push_back({2'd2, sp - 16'h4, 8'h40, vec[6:0], 1'b0});
        pulse(1'b0);
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (excBusy === 1'b1 && k < 30);
        chk("sequence end", 34'(k < 30), 34'h1);
    endtask : take

    task automatic wrap_up;
        chk("left over", 34'(expQ.size()), 34'h0);
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #800000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        idle(5);
        reset_n <= 1'b1;
        idle(6);
        rd(16'hffc4, 8'h09);
        rd(16'hffc6, 8'h00);
        rd(16'hffc7, 8'h00);
        rd(16'hffc0, 8'h00);
        ccMask <= 1'b0;
        extLines <= 8'hfe;
        idle(6);
        quiet(1'b0);
        wr(16'hffc7, 8'h24);
        extLines <= 8'hdb;
        ccMask <= 1'b1;
        idle(6);
        quiet(1'b0);
        ccMask <= 1'b0;
        take(8'h06);
        extLines <= 8'hdf;
        idle(6);
        take(8'h09);
        extLines <= 8'hff;
        wr(16'hffc6, 8'h80);
        wr(16'hffc7, 8'h80);
        ccMask <= 1'b1;
        extLines <= 8'h7f;
        idle(6);
        extLines <= 8'hff;
        wr(16'hffc7, 8'h00);
        ccMask <= 1'b0;
        quiet(1'b1);
        take(8'h0b);
        rd(16'hffc6, 8'h80);
        ccMask <= 1'b1;
        nmiPin <= 1'b0;
        idle(6);
        take(8'h03);
        nmiPin <= 1'b1;
        idle(6);
        quiet(1'b0);
        wr(16'hffc4, 8'h0d);
        rd(16'hffc4, 8'h0d);
        nmiPin <= 1'b0;
        idle(6);
        quiet(1'b0);
        nmiPin <= 1'b1;
        idle(6);
        take(8'h03);
        j = {$random(seed)} % 19;
        intEn[j] <= 1'b1;
        intFlags[j] <= 1'b1;
        quiet(1'b0);
        sleeping <= 1'b1;
        ccMask <= 1'b0;
        idle(3);
        @(negedge sys_clk);
        chk("wake", {33'h0, wakeCore}, 34'h1);
        @(posedge sys_clk);
        sleeping <= 1'b0;
        take(8'(12 + j));
        fork
            take(8'h00);
            begin
                repeat (2) @(posedge sys_clk);
                intFlags <= '0;
            end
        join
        ccMask <= 1'b1;
        @(posedge sys_clk);
        rte <= 1'b1;
        rteWord <= 16'($random(seed));
        @(posedge sys_clk);
        rte <= 1'b0;
        @(negedge sys_clk);
        chk("restore", {26'h0, ccRestore}, {26'h0, rteWord[15:8]});
        idle(4);
        wrap_up();
    end
endmodule : tb
